//--- common/tss_consts.svh
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

// ***********************************************************
// Register byte offsets
// ***********************************************************
`define TSS_OFF_CTRL   8'h00
`define TSS_OFF_STATUS 8'h04
`define TSS_OFF_X      8'h08
`define TSS_OFF_Y      8'h0C
`define TSS_OFF_Z1     8'h10
`define TSS_OFF_Z2     8'h14

// ***********************************************************
// Control field positions
// ***********************************************************
`define TSS_B_SRST     1
`define TSS_B_PSM      2
`define TSS_B_PENCFG   3
`define TSS_B_MODE     4
`define TSS_F_FUNC     8:5
`define TSS_F_MED      10:9
`define TSS_F_AVG      12:11
`define TSS_B_RES12    13
`define TSS_F_SETTLE   23:16
`define TSS_CTRL_RST   32'h0000_0000

// ***********************************************************
// Status field positions
// ***********************************************************
`define TSS_F_DAV      3:0
`define TSS_B_RSTFLAG  4
`define TSS_B_BUSY     5

// ***********************************************************
// Function codes and timing
// ***********************************************************
`define TSS_FUNC_XYZ   4'h0
`define TSS_FUNC_XY    4'h1
`define TSS_PCLK_NS    25
`define TSS_RST_ACC_NS 7500
`define TSS_RST_ACC_CYC ((`TSS_RST_ACC_NS + `TSS_PCLK_NS - 1) / `TSS_PCLK_NS)
`define TSS_POR_CYC    64
`define TSS_OH_XY_H    5
`define TSS_OH_XYZ_H   7
`define TSS_OH_SETTLE  10
`define TSS_CONVERSION_OVERHEAD    3
`define TSS_ADC_DIV    2

`endif

//--- common/tss_pkg.sv
package tss_pkg;

  typedef enum logic [2:0] {
    TSS_IDLE, TSS_START, TSS_SETTLE, TSS_CONV, TSS_FILT, TSS_NEXT, TSS_COMMIT
  } tss_state_t;

  typedef enum logic [1:0] {TSS_AX_Y, TSS_AX_X, TSS_AX_Z1, TSS_AX_Z2} tss_axis_t;

  typedef struct packed {
    logic y_en;
    logic x_en;
    logic z_en;
  } tss_drv_t;

  typedef struct packed {
    logic        pin_o;
    logic        pin_oe;
  } tss_pin_t;

endpackage : tss_pkg

//--- core/tss_reset_qual.sv
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_reset_qual (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // External reset pin
  input  wire logic reset_pin_n,
  // Qualified reset
  output logic      ext_rst
);

  logic [1:0] sync_r;
  logic       s3_r;
  logic       low_r;
  logic [9:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 2'b11;
      s3_r   <= 1'b1;
    end else begin
      sync_r <= {sync_r[0], reset_pin_n};
      s3_r   <= sync_r[1];
    end
  end

  // Two agreeing samples are needed to change level, so a short spike is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= 1'b0;
    end else if (!sync_r[1] && !s3_r) begin
      low_r <= 1'b1;
    end else if (sync_r[1] && s3_r) begin
      low_r <= 1'b0;
    end
  end

  // Low time is counted on pclk; acceptance lies between 5 us and 10 us.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 10'h000;
    end else if (!low_r) begin
      cnt_r <= 10'h000;
    end else if (cnt_r != 10'(`TSS_RST_ACC_CYC)) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_rst <= 1'b0;
    end else begin
      ext_rst <= low_r && (cnt_r == 10'(`TSS_RST_ACC_CYC));
    end
  end

endmodule : tss_reset_qual

//--- core/tss_core.sv
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_core
  import tss_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources
  input  wire logic        supply_good,
  input  wire logic        reset_pin_n,
  // Panel side
  input  wire logic        osc_clk,
  input  wire logic        pen_touch,
  input  wire logic [11:0] adc_data,
  output tss_drv_t         drv,
  output logic             adc_power_on,
  output logic             adc_sample,
  output logic             scan_busy,
  // Interrupt pin, open drain
  output tss_pin_t         pen_irq_or_data_ready_pin
);

  // ***********************************************************
  // Helper functions
  // ***********************************************************
  function automatic logic [5:0] filt_delay(input logic [1:0] m, input logic [1:0] w,
                                            input logic res12);
    logic [5:0] d;
    d = 6'h02;
    unique case (m)
      2'b00: d = 6'h02;
      2'b01: d = res12 ? 6'd28 : 6'd24;
      2'b10: d = (w == 2'b00) ? (res12 ? 6'd28 : 6'd24) : (res12 ? 6'd31 : 6'd27);
      2'b11: begin
        if (w == 2'b00) d = res12 ? 6'd31 : 6'd29;
        else if (w == 2'b01) d = res12 ? 6'd34 : 6'd32;
        else d = res12 ? 6'd38 : 6'd36;
      end
    endcase
    return d;
  endfunction : filt_delay

  function automatic logic [4:0] samples(input logic [1:0] m, input logic [1:0] w);
    logic [4:0] n;
    n = 5'd1;
    unique case (m)
      2'b01:   n = 5'd3;
      2'b10:   n = 5'd7;
      2'b11:   n = 5'd15;
      default: n = (w == 2'b00) ? 5'd1 : 5'(5'd2 << w);
    endcase
    return n;
  endfunction : samples

  // ***********************************************************
  // Reset sources
  // ***********************************************************
  logic [1:0] pg_sync_r;
  logic [6:0] por_cnt_r;
  logic       ext_rst;
  logic       hard_rst;
  logic       soft_rst;
  logic       any_rst;
  logic [31:0] ctrl_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pg_sync_r <= 2'b00;
    else pg_sync_r <= {pg_sync_r[0], supply_good};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt_r <= 7'h00;
    end else if (!pg_sync_r[1]) begin
      por_cnt_r <= 7'h00;
    end else if (por_cnt_r != 7'(`TSS_POR_CYC)) begin
      por_cnt_r <= por_cnt_r + 7'h01;
    end
  end

  tss_reset_qual u_rst_qual (
    .pclk        (pclk),
    .presetn     (presetn),
    .reset_pin_n (reset_pin_n),
    .ext_rst     (ext_rst)
  );

  assign hard_rst = (por_cnt_r != 7'(`TSS_POR_CYC)) || ext_rst;
  assign soft_rst = ctrl_r[`TSS_B_SRST];
  assign any_rst  = hard_rst || soft_rst;

  // ***********************************************************
  // Input synchronisers
  // ***********************************************************
  logic [2:0] osc_r;
  logic [1:0] pen_r;
  logic       pen;
  logic       pen_d_r;
  logic       half_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_r   <= 3'h0;
      pen_r   <= 2'h0;
      pen_d_r <= 1'b0;
    end else begin
      osc_r   <= {osc_r[1:0], osc_clk};
      pen_r   <= {pen_r[0], pen_touch};
      pen_d_r <= pen_r[1];
    end
  end

  assign pen       = pen_r[1];
  assign half_tick = osc_r[2] ^ osc_r[1];

  // ***********************************************************
  // APB register access
  // ***********************************************************
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  logic       host_go;
  logic [3:0] rd_hit;
  logic [3:0] dav_r;
  logic       rst_flag_r;
  logic [11:0] res_r [4];
  logic       busy;

  assign pready  = 1'b1;
  assign mapped  = (paddr <= `TSS_OFF_Z2) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;
  assign rd_en   = psel && penable && !pwrite && mapped;

  always_comb begin
    rd_hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (rd_en && (paddr == 8'(`TSS_OFF_X + 4 * i))) rd_hit[i] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TSS_CTRL_RST;
    end else if (hard_rst) begin
      ctrl_r <= `TSS_CTRL_RST;
    end else if (wr_en && (paddr == `TSS_OFF_CTRL)) begin
      if (soft_rst) ctrl_r <= `TSS_CTRL_RST | (pwdata & 32'h0000_0002);
      else ctrl_r <= pwdata;
    end
  end

  // A scan code written while the pen is down starts a host-initiated scan.
  assign host_go = wr_en && (paddr == `TSS_OFF_CTRL) && !soft_rst && pen
                   && pwdata[`TSS_B_MODE] && !pwdata[`TSS_B_SRST]
                   && (pwdata[`TSS_F_FUNC] <= `TSS_FUNC_XY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `TSS_OFF_CTRL:   prdata <= ctrl_r;
        `TSS_OFF_STATUS: prdata <= {26'h0, busy, rst_flag_r, dav_r};
        `TSS_OFF_X:      prdata <= {20'h0, res_r[0]};
        `TSS_OFF_Y:      prdata <= {20'h0, res_r[1]};
        `TSS_OFF_Z1:     prdata <= {20'h0, res_r[2]};
        `TSS_OFF_Z2:     prdata <= {20'h0, res_r[3]};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_flag_r <= 1'b0;
    end else if (any_rst) begin
      rst_flag_r <= 1'b0;
    end else if (rd_en && (paddr == `TSS_OFF_STATUS)) begin
      rst_flag_r <= 1'b1;
    end
  end

  // ***********************************************************
  // Scan sequencer
  // ***********************************************************
  tss_state_t  st_r;
  tss_axis_t   ax_r;
  logic [9:0]  tmr_r;
  logic [4:0]  n_r;
  logic [15:0] acc_r;
  logic [11:0] pick_r;
  logic [11:0] stage_r [4];
  logic        xyz_r;
  logic        commit;
  logic        tmr_done;
  logic        dev_go;
  logic [4:0]  n_need;
  logic [3:0]  bits;

  assign n_need   = samples(ctrl_r[`TSS_F_MED], ctrl_r[`TSS_F_AVG]);
  assign bits     = ctrl_r[`TSS_B_RES12] ? 4'd12 : 4'd10;
  assign tmr_done = (tmr_r == 10'h000);
  assign busy     = (st_r != TSS_IDLE);
  assign commit   = (st_r == TSS_COMMIT);
  assign dev_go   = pen && !pen_d_r && ctrl_r[`TSS_B_PSM] && !ctrl_r[`TSS_B_MODE]
                    && (ctrl_r[`TSS_F_FUNC] <= `TSS_FUNC_XY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= TSS_IDLE;
      ax_r  <= TSS_AX_Y;
      xyz_r <= 1'b0;
    end else if (any_rst) begin
      st_r  <= TSS_IDLE;
      ax_r  <= TSS_AX_Y;
      xyz_r <= 1'b0;
    end else if (busy && !commit && !pen) begin
      st_r <= TSS_IDLE;
    end else begin
      unique case (st_r)
        TSS_IDLE: begin
          if (dev_go || host_go) begin
            st_r  <= TSS_START;
            ax_r  <= TSS_AX_Y;
            xyz_r <= host_go ? (pwdata[`TSS_F_FUNC] == `TSS_FUNC_XYZ)
                             : (ctrl_r[`TSS_F_FUNC] == `TSS_FUNC_XYZ);
          end
        end
        TSS_START:  if (tmr_done) st_r <= TSS_SETTLE;
        TSS_SETTLE: if (tmr_done) st_r <= TSS_CONV;
        TSS_CONV:   if (tmr_done && (n_r == n_need)) st_r <= TSS_FILT;
        TSS_FILT:   if (tmr_done) st_r <= TSS_NEXT;
        TSS_NEXT: begin
          if (ax_r == TSS_AX_Y) begin
            ax_r <= TSS_AX_X;
            st_r <= TSS_SETTLE;
          end else if ((ax_r == TSS_AX_X) && xyz_r) begin
            ax_r <= TSS_AX_Z1;
            st_r <= TSS_SETTLE;
          end else if (ax_r == TSS_AX_Z1) begin
            ax_r <= TSS_AX_Z2;
            st_r <= TSS_CONV;
          end else begin
            st_r <= TSS_COMMIT;
          end
        end
        TSS_COMMIT: st_r <= TSS_IDLE;
      endcase
    end
  end

  // Start overhead is loaded in the cycle the scan is accepted.
  logic       go_xyz;
  logic [9:0] oh_load;
  assign go_xyz  = host_go ? (pwdata[`TSS_F_FUNC] == `TSS_FUNC_XYZ)
                           : (ctrl_r[`TSS_F_FUNC] == `TSS_FUNC_XYZ);
  assign oh_load = go_xyz ? 10'(`TSS_OH_XYZ_H) : 10'(`TSS_OH_XY_H);

  // Timer counts half cycles of the internal oscillator, so 2.5 cycles is exact.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= 10'h000;
    end else if (any_rst || !pen) begin
      tmr_r <= 10'h000;
    end else if (st_r == TSS_IDLE) begin
      tmr_r <= (dev_go || host_go) ? oh_load : 10'h000;
    end else if (!tmr_done) begin
      if (half_tick) tmr_r <= tmr_r - 10'h001;
    end else begin
      unique case (st_r)
        TSS_START: tmr_r <= 10'(2 * ({2'b00, ctrl_r[`TSS_F_SETTLE]} + `TSS_OH_SETTLE));
        TSS_SETTLE, TSS_CONV: begin
          if (st_r == TSS_CONV && n_r == n_need) begin
            tmr_r <= 10'(2 * filt_delay(ctrl_r[`TSS_F_MED], ctrl_r[`TSS_F_AVG],
                                        ctrl_r[`TSS_B_RES12]));
          end else if (st_r == TSS_CONV && (n_r + 5'h01) == n_need) begin
            tmr_r <= 10'h000;
          end else begin
            tmr_r <= 10'(2 * ((bits + 4'd2) * `TSS_ADC_DIV + `TSS_CONVERSION_OVERHEAD));
          end
        end
        TSS_NEXT: begin
          if (ax_r == TSS_AX_Z1) tmr_r <= 10'(2 * ((bits + 4'd2) * `TSS_ADC_DIV + `TSS_CONVERSION_OVERHEAD));
          else tmr_r <= 10'(2 * ({2'b00, ctrl_r[`TSS_F_SETTLE]} + `TSS_OH_SETTLE));
        end
        default: tmr_r <= 10'h000;
      endcase
    end
  end

  // Converter data is valid the cycle after the strobe, so it is taken one cycle late.
  logic adc_sample_r;
  logic adc_take_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) adc_take_r <= 1'b0;
    else adc_take_r <= adc_sample_r;
  end

  // Sample accumulation; median settings keep the centre sample in time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_r    <= 5'h00;
      acc_r  <= 16'h0000;
      pick_r <= 12'h000;
    end else if (st_r == TSS_SETTLE || st_r == TSS_NEXT || !busy) begin
      n_r   <= 5'h00;
      acc_r <= 16'h0000;
    end else begin
      if (st_r == TSS_CONV && tmr_done && n_r != n_need && adc_sample_r) n_r <= n_r + 5'h01;
      if (adc_take_r) begin
        acc_r <= acc_r + {4'h0, adc_data};
        if (n_r == (n_need >> 1) + 5'h01) pick_r <= adc_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) adc_sample_r <= 1'b0;
    else adc_sample_r <= (st_r == TSS_CONV) && (tmr_r == 10'h001) && half_tick;
  end
  assign adc_sample = adc_sample_r;

  // Staging registers hold each filtered axis until the set is complete.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) stage_r[i] <= 12'h000;
    end else if (any_rst) begin
      for (int i = 0; i < 4; i++) stage_r[i] <= 12'h000;
    end else if (st_r == TSS_FILT && tmr_done) begin
      if (ctrl_r[`TSS_F_MED] != 2'b00) stage_r[ax_r] <= pick_r;
      else stage_r[ax_r] <= 12'(acc_r >> ctrl_r[`TSS_F_AVG] >> (ctrl_r[`TSS_F_AVG] != 0));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) res_r[i] <= 12'h000;
    end else if (any_rst) begin
      for (int i = 0; i < 4; i++) res_r[i] <= 12'h000;
    end else if (commit) begin
      res_r[0] <= stage_r[TSS_AX_X];
      res_r[1] <= stage_r[TSS_AX_Y];
      if (xyz_r) begin
        res_r[2] <= stage_r[TSS_AX_Z1];
        res_r[3] <= stage_r[TSS_AX_Z2];
      end
    end
  end

  // Data-available bits: a commit in the same cycle as a read keeps the bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dav_r <= 4'h0;
    end else if (any_rst) begin
      dav_r <= 4'h0;
    end else begin
      dav_r <= (dav_r & ~rd_hit) | (commit ? {xyz_r, xyz_r, 2'b11} : 4'h0);
    end
  end

  // ***********************************************************
  // Panel drivers and interrupt pin
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv          <= '0;
      adc_power_on <= 1'b0;
      scan_busy    <= 1'b0;
      pen_irq_or_data_ready_pin <= '0;
    end else begin
      drv.y_en     <= busy && pen && !any_rst && (ax_r == TSS_AX_Y) && !commit;
      drv.x_en     <= busy && pen && !any_rst && (ax_r == TSS_AX_X) && !commit;
      drv.z_en     <= busy && pen && !any_rst && ax_r[1] && !commit;
      adc_power_on <= pen && !any_rst && (st_r == TSS_CONV || st_r == TSS_FILT);
      scan_busy    <= busy && !any_rst;
      pen_irq_or_data_ready_pin.pin_o  <= 1'b0;
      pen_irq_or_data_ready_pin.pin_oe <= !any_rst && (ctrl_r[`TSS_B_PENCFG] ?
                                          pen : (dav_r != 4'h0));
    end
  end

endmodule : tss_core

//--- sim/tss_core_sva.sv
`timescale 1ns/1ps
module tss_core_sva
  import tss_pkg::*;
(
  // Clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // Watched ports
  input wire logic     reset_pin_n,
  input wire logic     pen_touch,
  input wire tss_drv_t drv,
  input wire logic     adc_power_on,
  input wire logic     adc_sample,
  input wire logic     scan_busy,
  input wire tss_pin_t pen_irq_or_data_ready_pin
);
  // ***********************************************************
  // Helper logic
  // ***********************************************************
  logic [9:0] low_cnt_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts how long the external reset pin has been held low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 10'h000;
    end else if (reset_pin_n) begin
      low_cnt_r <= 10'h000;
    end else if (low_cnt_r != 10'h3FF) begin
      low_cnt_r <= low_cnt_r + 10'h001;
    end
  end

  // ***********************************************************
  // Properties
  // ***********************************************************
  property p_pin_low; pen_irq_or_data_ready_pin.pin_o == 1'b0; endproperty
  a_pin_low: assert property (p_pin_low) else $error("Pin driven high.");
  property p_first; $rose(scan_busy) |-> ##[0:2] (drv.y_en && !drv.x_en && !drv.z_en); endproperty
  a_first: assert property (p_first) else $error("Scan not on Y first.");
  property p_one_axis; $onehot0(drv); endproperty
  a_one_axis: assert property (p_one_axis) else $error("Two axes driven.");
  property p_smp_pwr; adc_sample |-> adc_power_on; endproperty
  a_smp_pwr: assert property (p_smp_pwr) else $error("Sample while unpowered.");
  property p_smp_gap; adc_sample |=> !adc_sample [*8]; endproperty
  a_smp_gap: assert property (p_smp_gap) else $error("Samples too close.");
  property p_smp_busy; adc_sample |-> scan_busy; endproperty
  a_smp_busy: assert property (p_smp_busy) else $error("Sample outside scan.");
  property p_idle_drv; !scan_busy [*2] |-> drv == 3'h0; endproperty
  a_idle_drv: assert property (p_idle_drv) else $error("Drivers on while idle.");
  property p_pen_up; !pen_touch [*8] |-> !scan_busy; endproperty
  a_pen_up: assert property (p_pen_up) else $error("Scan kept after pen up.");
  property p_pin_rst; low_cnt_r >= 10'h136 |-> !scan_busy && drv == 3'h0; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("Pin reset not applied.");

  c_start: cover property ($rose(scan_busy));
  c_end: cover property ($fell(scan_busy));
  c_smp: cover property (adc_sample);
  c_pin: cover property ($rose(pen_irq_or_data_ready_pin.pin_oe));
endmodule : tss_core_sva

bind tss_core tss_core_sva u_sva (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
  .pen_touch(pen_touch), .drv(drv), .adc_power_on(adc_power_on), .adc_sample(adc_sample),
  .scan_busy(scan_busy), .pen_irq_or_data_ready_pin(pen_irq_or_data_ready_pin));

//--- sim/tss_panel_model.sv
`timescale 1ns/1ps
module tss_panel_model
  import tss_pkg::*;
#(
  parameter logic [11:0] X_VAL  = 12'h000,
  parameter logic [11:0] Y_VAL  = 12'h000,
  parameter logic [11:0] Z1_VAL = 12'h000,
  parameter logic [11:0] Z2_VAL = 12'h000
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Panel side
  input  wire logic        osc_run,
  input  wire tss_drv_t    drv,
  input  wire logic        adc_sample,
  input  wire logic [11:0] bias,
  output logic             osc_clk,
  output logic      [11:0] adc_data
);
  // ***********************************************************
  // Oscillator and converter
  // ***********************************************************
  logic z2_r;

  // The oscillator stands still while the pen is up and no scan runs.
  initial begin
    osc_clk = 1'b0;
    #37;
    forever begin
      #100;
      osc_clk = osc_run & ~osc_clk;
    end
  end

  // A result is valid one cycle after the strobe, then the bus churns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_data <= 12'h000;
      z2_r     <= 1'b0;
    end else if (adc_sample) begin
      adc_data <= bias + (drv.y_en ? Y_VAL : drv.x_en ? X_VAL : z2_r ? Z2_VAL : Z1_VAL);
      z2_r     <= drv.z_en & ~z2_r;
    end else begin
      adc_data <= ~adc_data;
      z2_r     <= z2_r & drv.z_en;
    end
  end
endmodule : tss_panel_model

//--- sim/tss_core_tb.sv
`timescale 1ns/1ps
`include "tss_consts.svh"
module tss_core_tb
  import tss_pkg::*;
;
  // ***********************************************************
  // Wiring
  // ***********************************************************
  localparam logic [11:0] VALS [0:3] = '{12'h5A3, 12'h3C7, 12'h1E4, 12'h6B2};
  localparam logic [31:0] DEV_XY = 32'h0002_202C;
  localparam logic [31:0] HOST_XYZ = 32'h0002_2010;
  localparam int XY_CYC = 740;
  localparam int XYZ_CYC = 1372;
  logic pclk, presetn, psel, penable, pwrite, supply_good, reset_pin_n, pen_touch;
  logic pready, pslverr, osc_clk, adc_power_on, adc_sample, scan_busy, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [11:0] adc_data, bias;
  tss_drv_t drv;
  tss_pin_t pin;
  int miscompares, comparisons, n, samples;

  tss_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_good(supply_good), .reset_pin_n(reset_pin_n),
    .osc_clk(osc_clk), .pen_touch(pen_touch), .adc_data(adc_data), .drv(drv),
    .adc_power_on(adc_power_on), .adc_sample(adc_sample), .scan_busy(scan_busy),
    .pen_irq_or_data_ready_pin(pin));
  tss_panel_model #(.X_VAL(VALS[0]), .Y_VAL(VALS[1]), .Z1_VAL(VALS[2]), .Z2_VAL(VALS[3]))
    u_panel (.pclk(pclk), .presetn(presetn), .osc_run(pen_touch | scan_busy), .drv(drv),
    .adc_sample(adc_sample), .bias(bias), .osc_clk(osc_clk), .adc_data(adc_data));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (adc_sample === 1'b1) samples++;

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      chk(0, 1, "no pready");
      summarize();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (scan_busy !== lvl) begin
      @(negedge pclk);
      n++;
      if (n > 6000) begin
        chk(0, 1, "busy wait timed out");
        summarize();
      end
    end
  endtask : wait_busy
  task automatic pen(input logic v);
    @(posedge pclk);
    pen_touch <= v;
  endtask : pen

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_defaults;
    apb(0, `TSS_OFF_CTRL, 0);
    chk(d, 0, "ctrl after stretch");
    apb(0, `TSS_OFF_STATUS, 0);
    chk(d[4], 0, "reset flag");
    apb(0, `TSS_OFF_STATUS, 0);
    chk(d[4], 1, "reset flag poll");
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(8'h08 + 4 * i), 0);
      chk(d, 0, "result default");
    end
    apb(0, 8'h18, 0);
    chk(e, 1, "unmapped error");
    $display("defaults done");
  endtask : t_defaults
  task automatic t_dev_xy;
    apb(1, `TSS_OFF_CTRL, DEV_XY);
    pen(1);
    wait_busy(1);
    chk(pin.pin_oe, 1, "pen pin");
    wait_busy(0);
    chk(n > XY_CYC - 16 && n < XY_CYC + 16, 1, "xy time");
    apb(0, `TSS_OFF_STATUS, 0);
    chk($countones(d[3:0]), 2, "xy flags");
    apb(0, `TSS_OFF_X, 0);
    chk(d, VALS[0], "x");
    apb(0, `TSS_OFF_Y, 0);
    chk(d, VALS[1], "y");
    apb(0, `TSS_OFF_Z1, 0);
    chk(d, 0, "z1 kept");
    apb(0, `TSS_OFF_STATUS, 0);
    chk(d[3:0], 0, "flags cleared");
    pen(0);
    $display("device xy done");
  endtask : t_dev_xy
  task automatic t_host_xyz;
    apb(1, `TSS_OFF_CTRL, HOST_XYZ);
    pen(1);
    repeat (40) @(posedge pclk);
    chk(scan_busy, 0, "host waits");
    apb(1, `TSS_OFF_CTRL, HOST_XYZ);
    wait_busy(1);
    wait_busy(0);
    chk(n > XYZ_CYC - 16 && n < XYZ_CYC + 16, 1, "xyz time");
    repeat (2) @(posedge pclk);
    chk(pin.pin_oe, 1, "data pin");
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(8'h08 + 4 * i), 0);
      chk(d, VALS[i], "xyz result");
    end
    repeat (3) @(posedge pclk);
    chk(pin.pin_oe, 0, "data pin off");
    pen(0);
    $display("host xyz done");
  endtask : t_host_xyz
  task automatic t_filter;
    bias <= 12'h011;
    apb(1, `TSS_OFF_CTRL, DEV_XY | 32'h0000_0800);
    pen(1);
    samples = 0;
    wait_busy(1);
    wait_busy(0);
    chk(samples, 8, "samples");
    apb(0, `TSS_OFF_X, 0);
    chk(d, VALS[0] + 12'h011, "filtered x");
    pen(0);
    $display("filter done");
  endtask : t_filter
  task automatic t_abort;
    bias <= 12'h022;
    apb(1, `TSS_OFF_CTRL, DEV_XY);
    pen(1);
    wait_busy(1);
    repeat (200) @(posedge pclk);
    pen(0);
    wait_busy(0);
    chk(n < 12, 1, "abort time");
    chk({29'h0, drv}, 0, "drivers off");
    apb(0, `TSS_OFF_X, 0);
    chk(d, VALS[0] + 12'h011, "x kept");
    $display("abort done");
  endtask : t_abort
  task automatic t_soft;
    apb(1, `TSS_OFF_CTRL, 32'h2);
    apb(0, `TSS_OFF_X, 0);
    chk(d, 0, "soft clears");
    apb(1, `TSS_OFF_CTRL, 32'h6);
    apb(0, `TSS_OFF_CTRL, 0);
    chk(d, 32'h2, "held in soft");
    apb(1, `TSS_OFF_CTRL, 32'h0);
    apb(0, `TSS_OFF_STATUS, 0);
    chk(d[4], 0, "soft flag");
    $display("soft reset done");
  endtask : t_soft
  task automatic t_pin;
    apb(1, `TSS_OFF_CTRL, DEV_XY);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    @(posedge pclk);
    reset_pin_n <= 1'b1;
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (100) @(posedge pclk);
    reset_pin_n <= 1'b1;
    apb(0, `TSS_OFF_CTRL, 0);
    chk(d, DEV_XY, "short low kept");
    apb(1, `TSS_OFF_CTRL, 32'h2);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (420) @(posedge pclk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(0, `TSS_OFF_CTRL, 0);
    chk(d, 0, "pin clears soft");
    $display("pin reset done");
  endtask : t_pin

  initial begin
    {presetn, psel, penable, pwrite, pen_touch} = 5'h00;
    {supply_good, reset_pin_n} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bias = 12'h000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, `TSS_OFF_CTRL, 32'h2C);
    repeat (70) @(posedge pclk);
    t_defaults();
    t_dev_xy();
    t_host_xyz();
    t_filter();
    t_abort();
    t_soft();
    t_pin();
    summarize();
  end
endmodule : tss_core_tb
